// ---- acf_filter_cmd.sv ----
// Purpose: anti-collision filter command handler and echo check
// Assumes: host and reader streams are synchronous to clock
// Notes: CRC of reader frames is stripped/added by the frame layer
`timescale 1ns/10ps
module acf_filter_cmd
	import acf_pkg::*;
#(
	parameter int CAP_DEPTH  = ACF_CAP_DEPTH,
	parameter int FIFO_DEPTH = ACF_FIFO_DEPTH
)
(
	// clock and reset
	input  wire logic       clock,
	input  wire logic       rst_n,
	// host command stream
	input  wire logic       cmd_valid,
	input  wire logic [7:0] cmd_data,
	input  wire logic       cmd_last,
	output logic            cmd_ready,
	// host response stream
	output logic            rsp_valid,
	output logic      [7:0] rsp_data,
	output logic            rsp_last,
	input  wire logic       rsp_ready,
	// listening mode
	input  wire logic       listen_start,
	output logic            listening,
	// reader frames in
	input  wire logic       rdr_valid,
	input  wire logic [7:0] rdr_data,
	input  wire logic       rdr_last,
	input  wire logic       rdr_short,
	output logic            rdr_ready,
	// answers to reader
	output logic            ans_valid,
	output logic      [7:0] ans_data,
	output logic            ans_last,
	input  wire logic       ans_ready,
	// buffered reader commands for host
	output logic            buf_valid,
	output logic      [7:0] buf_data,
	output logic            buf_last,
	input  wire logic       buf_ready,
	// status
	output logic            filter_on,
	output logic      [7:0] tag_state
);

	localparam int CW = $clog2(CAP_DEPTH + 1);
	localparam int PW = $clog2(CAP_DEPTH);

	typedef enum logic [2:0] {H_CODE, H_LEN, H_DATA, H_SKIP, H_RESP} acf_hst_t;
	typedef enum logic [1:0] {R_CAP, R_DEC, R_ANS, R_PUSH} acf_rst_t;

	// ----
	// helpers
	// ----
	function automatic logic [1:0] lvl_of(input logic [7:0] c);
		case (c)
			ACF_RQ_SEL_CL1: lvl_of = 2'h0;
			ACF_RQ_SEL_CL2: lvl_of = 2'h1;
			ACF_RQ_SEL_CL3: lvl_of = 2'h2;
			default:        lvl_of = 2'h3;
		endcase
	endfunction

	function automatic logic [7:0] bcc4(input logic [7:0] a, input logic [7:0] b,
		input logic [7:0] c, input logic [7:0] d);
		bcc4 = a ^ b ^ c ^ d;
	endfunction

	// ----
	// declarations
	// ----
	acf_hst_t    hst_ff;
	acf_hst_t    nxt_hst;
	acf_rst_t    rst_ff;
	acf_rst_t    nxt_rst;
	logic        cmd_ready_ff;
	logic        cmd_fire;
	logic [7:0]  hlen_ff;
	logic [7:0]  hcnt_ff;
	logic [7:0]  pay_ff [ACF_MAX_CFG];
	logic        go_echo_ff;
	logic        go_filt_ff;
	logic [7:0]  nxt_rb [3];
	logic [1:0]  nxt_rn;
	logic        host_st_we;
	logic        cfg_we;
	logic        filt_we;
	logic        filt_val;
	logic [7:0]  rb_ff [3];
	logic [1:0]  rn_ff;
	logic [1:0]  ri_ff;
	logic        rsp_valid_ff;
	logic [7:0]  rsp_data_ff;
	logic        rsp_last_ff;
	logic        listening_ff;
	logic        filt_ff;
	logic [7:0]  tag_state_ff;
	logic [7:0]  atqa_ff [2];
	logic [7:0]  sak_ff;
	logic [7:0]  uid_ff [ACF_UID_MAX];
	logic [1:0]  lvls_ff;
	logic        rdr_ready_ff;
	logic        rdr_fire;
	logic [7:0]  cap_ff [CAP_DEPTH];
	logic [CW-1:0] capn_ff;
	logic        cshort_ff;
	logic [CW-1:0] pi_ff;
	logic [1:0]  lvl;
	logic [1:0]  lsel;
	logic        lvl_ok;
	logic        rdy;
	logic        final_lvl;
	logic [7:0]  ua [4];
	logic [7:0]  ubcc;
	logic        dec_hit;
	logic [2:0]  dec_n;
	logic [7:0]  dab [5];
	logic        rdr_st_we;
	logic [7:0]  rdr_st_val;
	logic [7:0]  ab_ff [5];
	logic [2:0]  an_ff;
	logic [2:0]  ai_ff;
	logic        ans_valid_ff;
	logic [7:0]  ans_data_ff;
	logic        ans_last_ff;
	logic        push_valid;
	logic        push_last;
	logic        push_ready;
	logic [8:0]  fifo_out;

	assign cmd_fire = cmd_valid & cmd_ready_ff;
	assign rdr_fire = rdr_valid & rdr_ready_ff;

	// ----
	// host command parser
	// ----
	always_comb
	begin
		nxt_hst = hst_ff;
		case (hst_ff)
			H_CODE:
				if (cmd_fire)
				begin
					if (cmd_data == ACF_CMD_ECHO && cmd_last)
						nxt_hst = H_RESP;                         // [RULE_11]
					else if (cmd_data == ACF_CMD_FILTER && !cmd_last)
						nxt_hst = H_LEN;                          // [RULE_01]
					else if (!cmd_last)
						nxt_hst = H_SKIP;
				end
			H_LEN:
				if (cmd_fire)
					nxt_hst = cmd_last ? H_RESP : H_DATA;
			H_DATA:
				if (cmd_fire && cmd_last)
					nxt_hst = H_RESP;
			H_SKIP:
				if (cmd_fire && cmd_last)
					nxt_hst = H_CODE;
			H_RESP:
				if (rsp_valid_ff && rsp_ready && rsp_last_ff)
					nxt_hst = H_CODE;
			default:
				nxt_hst = H_CODE;
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			hst_ff       <= H_CODE;
			cmd_ready_ff <= 1'b0;
			go_echo_ff   <= 1'b0;
			go_filt_ff   <= 1'b0;
		end
		else
		begin
			hst_ff       <= nxt_hst;
			cmd_ready_ff <= (nxt_hst != H_RESP);
			go_echo_ff   <= cmd_fire && hst_ff == H_CODE && nxt_hst == H_RESP;
			go_filt_ff   <= cmd_fire && hst_ff != H_CODE && nxt_hst == H_RESP;
		end
	end

	// payload capture; execution waits one cycle so the last byte is stored
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			hlen_ff <= ACF_LEN_OFF;
			hcnt_ff <= '0;
		end
		else if (cmd_fire && hst_ff == H_LEN)
		begin
			hlen_ff <= cmd_data;
			hcnt_ff <= '0;
		end
		else if (cmd_fire && hst_ff == H_DATA)
		begin
			if (hcnt_ff < 8'(ACF_MAX_CFG))
				pay_ff[hcnt_ff[3:0]] <= cmd_data;
			if (hcnt_ff != 8'hFF)
				hcnt_ff <= hcnt_ff + 8'h01;
		end
	end

	// ----
	// filter command execution
	// ----
	always_comb
	begin
		nxt_rb[0]  = ACF_RES_OK;
		nxt_rb[1]  = ACF_RSP_EMPTY;
		nxt_rb[2]  = tag_state_ff;
		nxt_rn     = 2'h2;
		host_st_we = 1'b0;
		cfg_we     = 1'b0;
		filt_we    = 1'b0;
		filt_val   = 1'b0;
		if (go_echo_ff)
		begin
			nxt_rb[0] = ACF_CMD_ECHO;                             // [RULE_11]
			nxt_rn    = 2'h1;
		end
		else
		begin
			case (hlen_ff)
				ACF_LEN_OFF:
				begin
					filt_we   = 1'b1;                             // [RULE_13]
					nxt_rb[1] = ACF_RSP_ONE;
					nxt_rn    = 2'h3;
				end
				ACF_LEN_SET:
					if (hcnt_ff == 8'h01)
						host_st_we = 1'b1;                        // [RULE_02]
					else
						nxt_rb[0] = ACF_RES_BADLEN;
				ACF_LEN_GET:
				begin
					nxt_rb[1] = ACF_RSP_ONE;                      // [RULE_03]
					nxt_rn    = 2'h3;
				end
				ACF_LEN_CL1, ACF_LEN_CL2, ACF_LEN_CL3:
					if (hcnt_ff == hlen_ff)
					begin
						cfg_we   = 1'b1;                          // [RULE_14]
						filt_we  = 1'b1;
						filt_val = 1'b1;
					end
					else
						nxt_rb[0] = ACF_RES_BADLEN;
				default:
					nxt_rb[0] = ACF_RES_BADLEN;                   // [RULE_15]
			endcase
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			filt_ff <= 1'b0;
			lvls_ff <= 2'h1;
			sak_ff  <= '0;
			for (int k = 0; k < 2; k++)
				atqa_ff[k] <= '0;
			for (int k = 0; k < ACF_UID_MAX; k++)
				uid_ff[k] <= '0;
		end
		else if (go_filt_ff)
		begin
			if (filt_we)
				filt_ff <= filt_val;                              // [RULE_01]
			if (cfg_we)
			begin
				atqa_ff[0] <= pay_ff[0];
				atqa_ff[1] <= pay_ff[1];
				sak_ff     <= pay_ff[2];
				for (int k = 0; k < ACF_UID_MAX; k++)
					uid_ff[k] <= pay_ff[k + ACF_UID_OFS];
				lvls_ff <= (hlen_ff == ACF_LEN_CL1) ? 2'h1 :
				           (hlen_ff == ACF_LEN_CL2) ? 2'h2 : 2'h3;
			end
		end
	end

	// host write wins over a reader-driven step in the same cycle
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			tag_state_ff <= ACF_ST_IDLE;
		else if (go_filt_ff && host_st_we)
			tag_state_ff <= pay_ff[0];                            // [RULE_02]
		else if (rdr_st_we)
			tag_state_ff <= rdr_st_val;                           // [RULE_04]
	end

	// set by a listen command, ended only by the echo check
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			listening_ff <= 1'b0;
		else if (listen_start)
			listening_ff <= 1'b1;
		else if (go_echo_ff)
			listening_ff <= 1'b0;                                 // [RULE_12]
	end

	// ----
	// host response streamer
	// ----
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			rsp_valid_ff <= 1'b0;
			rsp_data_ff  <= '0;
			rsp_last_ff  <= 1'b0;
			rn_ff        <= 2'h1;
			ri_ff        <= '0;
			for (int k = 0; k < 3; k++)
				rb_ff[k] <= '0;
		end
		else if (go_echo_ff || go_filt_ff)
		begin
			rb_ff        <= nxt_rb;
			rn_ff        <= nxt_rn;
			rsp_valid_ff <= 1'b1;
			rsp_data_ff  <= nxt_rb[0];
			rsp_last_ff  <= (nxt_rn == 2'h1);
			ri_ff        <= 2'h1;
		end
		else if (rsp_valid_ff && rsp_ready)
		begin
			if (rsp_last_ff)
				rsp_valid_ff <= 1'b0;
			else
			begin
				rsp_data_ff <= rb_ff[ri_ff];
				rsp_last_ff <= (ri_ff == 2'(rn_ff - 2'h1));
				ri_ff       <= ri_ff + 2'h1;
			end
		end
	end

	// ----
	// reader frame capture
	// ----
	always_comb
	begin
		nxt_rst = rst_ff;
		case (rst_ff)
			R_CAP:
				if (rdr_fire && rdr_last)
					nxt_rst = R_DEC;
			R_DEC:
				if (!filt_ff)
					nxt_rst = R_PUSH;                             // [RULE_05]
				else if (!dec_hit)
					nxt_rst = R_PUSH;                             // [RULE_07]
				else if (dec_n != 3'h0)
					nxt_rst = R_ANS;                              // [RULE_06]
				else
					nxt_rst = R_CAP;
			R_ANS:
				if (ans_valid_ff && ans_ready && ans_last_ff)
					nxt_rst = R_CAP;
			R_PUSH:
				if (push_ready && push_last)
					nxt_rst = R_CAP;
			default:
				nxt_rst = R_CAP;
		endcase
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			rst_ff       <= R_CAP;
			rdr_ready_ff <= 1'b0;
		end
		else
		begin
			rst_ff       <= nxt_rst;
			rdr_ready_ff <= (nxt_rst == R_CAP);
		end
	end

	// bytes past the capture depth are dropped
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			capn_ff   <= '0;
			cshort_ff <= 1'b0;
		end
		else if (rst_ff == R_CAP && rdr_fire)
		begin
			if (capn_ff < CW'(CAP_DEPTH))
			begin
				cap_ff[capn_ff[PW-1:0]] <= rdr_data;
				capn_ff <= capn_ff + CW'(1);
			end
			if (rdr_last)
				cshort_ff <= rdr_short;
		end
		else if (rst_ff != R_CAP && nxt_rst == R_CAP)
			capn_ff <= '0;
	end

	// ----
	// anti-collision decode
	// ----
	assign lvl       = lvl_of(cap_ff[0]);
	assign lvl_ok    = (lvl != 2'h3) && (lvl < lvls_ff);
	assign lsel      = lvl_ok ? lvl : 2'h0;
	assign rdy       = (tag_state_ff[6:0] == 7'(lsel) + 7'h01);
	assign final_lvl = (lsel == 2'(lvls_ff - 2'h1));
	assign ubcc      = bcc4(ua[0], ua[1], ua[2], ua[3]);

	always_comb
	begin
		for (int k = 0; k < 4; k++)
			ua[k] = uid_ff[{lsel, k[1:0]}];
	end

	always_comb
	begin
		dec_hit    = 1'b0;
		dec_n      = 3'h0;
		rdr_st_we  = 1'b0;
		rdr_st_val = tag_state_ff;
		for (int k = 0; k < 5; k++)
			dab[k] = '0;
		if (cshort_ff && capn_ff == CW'(1) && cap_ff[0] == ACF_RQ_SENS)
		begin
			dec_hit = 1'b1;                                       // [RULE_08]
			if (tag_state_ff == ACF_ST_IDLE)
			begin
				dab[0]     = atqa_ff[0];
				dab[1]     = atqa_ff[1];
				dec_n      = 3'h2;
				rdr_st_we  = 1'b1;
				rdr_st_val = ACF_ST_READY_A;
			end
		end
		else if (cshort_ff && capn_ff == CW'(1) && cap_ff[0] == ACF_RQ_ALL)
		begin
			dec_hit = 1'b1;                                       // [RULE_08]
			if (tag_state_ff == ACF_ST_IDLE || tag_state_ff == ACF_ST_HALT)
			begin
				dab[0]     = atqa_ff[0];
				dab[1]     = atqa_ff[1];
				dec_n      = 3'h2;
				rdr_st_we  = 1'b1;
				rdr_st_val = (tag_state_ff == ACF_ST_HALT) ? ACF_ST_READY_A_S
				                                           : ACF_ST_READY_A;
			end
		end
		else if (!cshort_ff && lvl_ok && capn_ff == CW'(ACF_SDD_LEN)
		         && cap_ff[1] == ACF_NVB_SDD)
		begin
			dec_hit = 1'b1;                                       // [RULE_09]
			if (rdy)
			begin
				for (int k = 0; k < 4; k++)
					dab[k] = ua[k];
				dab[4] = ubcc;
				dec_n  = 3'h5;
			end
		end
		else if (!cshort_ff && lvl_ok && capn_ff >= CW'(ACF_SEL_MIN_LEN)
		         && cap_ff[1] == ACF_NVB_SEL)
		begin
			dec_hit = 1'b1;                                       // [RULE_09]
			if (rdy && cap_ff[2] == ua[0] && cap_ff[3] == ua[1] && cap_ff[4] == ua[2]
			    && cap_ff[5] == ua[3] && cap_ff[6] == ubcc)
			begin
				dab[0]     = final_lvl ? sak_ff : ACF_SAK_CASCADE;
				dec_n      = 3'h1;
				rdr_st_we  = 1'b1;
				rdr_st_val = final_lvl ? ACF_ST_ACTIVE : tag_state_ff + 8'h01;
			end
		end
		if (rst_ff != R_DEC || !filt_ff)
		begin
			dec_n     = 3'h0;
			rdr_st_we = 1'b0;
		end
	end

	// ----
	// reader answer streamer
	// ----
	// listening is left as it is while answering the reader [RULE_10]
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			ans_valid_ff <= 1'b0;
			ans_data_ff  <= '0;
			ans_last_ff  <= 1'b0;
			an_ff        <= 3'h1;
			ai_ff        <= '0;
			for (int k = 0; k < 5; k++)
				ab_ff[k] <= '0;
		end
		else if (dec_n != 3'h0)
		begin
			ab_ff        <= dab;
			an_ff        <= dec_n;
			ans_valid_ff <= 1'b1;                                 // [RULE_06]
			ans_data_ff  <= dab[0];
			ans_last_ff  <= (dec_n == 3'h1);
			ai_ff        <= 3'h1;
		end
		else if (ans_valid_ff && ans_ready)
		begin
			if (ans_last_ff)
				ans_valid_ff <= 1'b0;
			else
			begin
				ans_data_ff <= ab_ff[ai_ff];
				ans_last_ff <= (ai_ff == 3'(an_ff - 3'h1));
				ai_ff       <= ai_ff + 3'h1;
			end
		end
	end

	// ----
	// receive buffer for the host
	// ----
	assign push_valid = (rst_ff == R_PUSH);
	assign push_last  = (pi_ff == CW'(capn_ff - CW'(1)));

	// a full buffer stalls the push and so the reader capture
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			pi_ff <= '0;
		else if (push_valid && push_ready)
			pi_ff <= pi_ff + CW'(1);                              // [RULE_05]
		else if (!push_valid)
			pi_ff <= '0;
	end

	acf_fifo #(
		.WIDTH (ACF_FIFO_WIDTH),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clock     (clock),
		.rst_n     (rst_n),
		.in_valid  (push_valid),
		.in_data   ({push_last, cap_ff[pi_ff[PW-1:0]]}),
		.in_ready  (push_ready),
		.out_valid (buf_valid),
		.out_data  (fifo_out),
		.out_ready (buf_ready)
	);

	// ----
	// outputs
	// ----
	assign buf_data  = fifo_out[7:0];
	assign buf_last  = fifo_out[8];
	assign cmd_ready = cmd_ready_ff;
	assign rsp_valid = rsp_valid_ff;
	assign rsp_data  = rsp_data_ff;
	assign rsp_last  = rsp_last_ff;
	assign listening = listening_ff;
	assign rdr_ready = rdr_ready_ff;
	assign ans_valid = ans_valid_ff;
	assign ans_data  = ans_data_ff;
	assign ans_last  = ans_last_ff;
	assign filter_on = filt_ff;
	assign tag_state = tag_state_ff;

endmodule

// ---- acf_pkg.sv ----
// Purpose: shared constants for the anti-collision filter command block
// Assumes: byte-wide host command, host response and reader frame streams
// Notes: tag state bytes follow the Type A tag state machine
// Functional notes
// RULE_01 - command 0D selects the filter functions
// RULE_02 - length 1 forces tag state, answers 00 00
// RULE_03 - length 2 reports state, filter unchanged
// RULE_04 - state byte: idle, ready, active, halt, starred
// RULE_05 - filter off: buffer every reader command
// RULE_06 - filter on: run anti-collision without host
// RULE_07 - filter on: buffer undecoded reader commands
// RULE_08 - answer 7-bit SENS 26 and ALL 52
// RULE_09 - answer SDD 93/95/97 and SEL x70
// RULE_10 - stay listening after anti-collision answers
// RULE_11 - echo byte 55 answers 55
// RULE_12 - echo ends listening without error
// RULE_13 - length 0 disables filter, reports state
// RULE_14 - lengths 7/11/15 load config, enable filter
// RULE_15 - other length above 2 answers 82 00
package acf_pkg;

	// ----
	// host command codes and answers
	// ----
	localparam logic [7:0] ACF_CMD_FILTER = 8'h0D;
	localparam logic [7:0] ACF_CMD_ECHO   = 8'h55;
	localparam logic [7:0] ACF_RES_OK     = 8'h00;
	localparam logic [7:0] ACF_RES_BADLEN = 8'h82;
	localparam logic [7:0] ACF_RSP_EMPTY  = 8'h00;
	localparam logic [7:0] ACF_RSP_ONE    = 8'h01;

	// ----
	// filter command lengths
	// ----
	localparam logic [7:0] ACF_LEN_OFF = 8'h00;
	localparam logic [7:0] ACF_LEN_SET = 8'h01;
	localparam logic [7:0] ACF_LEN_GET = 8'h02;
	localparam logic [7:0] ACF_LEN_CL1 = 8'h07;
	localparam logic [7:0] ACF_LEN_CL2 = 8'h0B;
	localparam logic [7:0] ACF_LEN_CL3 = 8'h0F;
	localparam int         ACF_MAX_CFG = 15;
	localparam int         ACF_UID_MAX = 12;
	localparam int         ACF_UID_OFS = 3;

	// ----
	// tag state encoding
	// ----
	localparam logic [7:0] ACF_ST_IDLE      = 8'h00;
	localparam logic [7:0] ACF_ST_READY_A   = 8'h01;
	localparam logic [7:0] ACF_ST_ACTIVE    = 8'h04;
	localparam logic [7:0] ACF_ST_HALT      = 8'h80;
	localparam logic [7:0] ACF_ST_READY_A_S = 8'h81;

	// ----
	// reader requests
	// ----
	localparam logic [7:0] ACF_RQ_SENS     = 8'h26;
	localparam logic [7:0] ACF_RQ_ALL      = 8'h52;
	localparam logic [7:0] ACF_RQ_SEL_CL1  = 8'h93;
	localparam logic [7:0] ACF_RQ_SEL_CL2  = 8'h95;
	localparam logic [7:0] ACF_RQ_SEL_CL3  = 8'h97;
	localparam logic [7:0] ACF_NVB_SDD     = 8'h20;
	localparam logic [7:0] ACF_NVB_SEL     = 8'h70;
	localparam logic [7:0] ACF_SAK_CASCADE = 8'h04;
	localparam int         ACF_SDD_LEN     = 2;
	localparam int         ACF_SEL_MIN_LEN = 7;

	// ----
	// buffer sizes
	// ----
	localparam int ACF_CAP_DEPTH  = 16;
	localparam int ACF_FIFO_DEPTH = 8;
	localparam int ACF_FIFO_WIDTH = 9;

endpackage

// ---- acf_fifo.sv ----
// Purpose: synchronous FIFO between the reader capture and the host
// Assumes: single clock, synchronous active-low reset
// Notes: in_ready falls only when every slot holds a word
`timescale 1ns/10ps
module acf_fifo
	import acf_pkg::*;
#(
	parameter int WIDTH = ACF_FIFO_WIDTH,
	parameter int DEPTH = ACF_FIFO_DEPTH
)
(
	// clock and reset
	input  wire logic             clock,
	input  wire logic             rst_n,
	// fill side
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	// drain side
	output logic                  out_valid,
	output logic      [WIDTH-1:0] out_data,
	input  wire logic             out_ready
);

	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0]    wr_ff;
	logic [AW-1:0]    rd_ff;
	logic [AW:0]      cnt_ff;
	logic             push;
	logic             pop;

	function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
		ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
	endfunction

	assign in_ready  = (cnt_ff != (AW+1)'(DEPTH));
	assign out_valid = (cnt_ff != '0);
	assign out_data  = mem_ff[rd_ff];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always_ff @(posedge clock)
	begin
		if (push)
		begin
			mem_ff[wr_ff] <= in_data;
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			wr_ff  <= '0;
			rd_ff  <= '0;
			cnt_ff <= '0;
		end
		else
		begin
			if (push)
			begin
				wr_ff <= ptr_inc(wr_ff);
			end
			if (pop)
			begin
				rd_ff <= ptr_inc(rd_ff);
			end
			if (push && !pop)
			begin
				cnt_ff <= cnt_ff + 1'b1;
			end
			else if (pop && !push)
			begin
				cnt_ff <= cnt_ff - 1'b1;
			end
		end
	end

endmodule

// ---- acf_checker.sv ----
// Purpose: port assertions for the filter command block
// Assumes: bound to acf_filter_cmd
// Notes: frame position kept in helper flops
`timescale 1ns/10ps
module acf_checker
	import acf_pkg::*;
(
	// clock and reset
	input wire logic       clock,
	input wire logic       rst_n,
	// host side
	input wire logic       cmd_valid,
	input wire logic [7:0] cmd_data,
	input wire logic       cmd_last,
	input wire logic       cmd_ready,
	input wire logic       rsp_valid,
	input wire logic [7:0] rsp_data,
	input wire logic       rsp_last,
	input wire logic       rsp_ready,
	input wire logic       listening,
	// reader side
	input wire logic       rdr_valid,
	input wire logic [7:0] rdr_data,
	input wire logic       rdr_last,
	input wire logic       rdr_short,
	input wire logic       rdr_ready,
	input wire logic       ans_valid,
	input wire logic       buf_valid,
	input wire logic       filter_on,
	input wire logic [7:0] tag_state
);
	logic [1:0] cidx_ff;
	logic [7:0] cprev_ff;
	logic       rfirst_ff;
	logic       ctake;
	logic       rtake;
	assign ctake = cmd_valid && cmd_ready;
	assign rtake = rdr_valid && rdr_ready;
	always_ff @(posedge clock)
	begin
		if (!rst_n || (ctake && cmd_last))
			cidx_ff <= 2'h0;
		else if (ctake && cidx_ff != 2'h3)
			cidx_ff <= cidx_ff + 2'h1;
	end
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			cprev_ff <= 8'h00;
		else if (ctake)
			cprev_ff <= cmd_data;
	end
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			rfirst_ff <= 1'b1;
		else if (rtake)
			rfirst_ff <= rdr_last;
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	sequence s_solo(logic [7:0] b);
		ctake && cmd_last && cidx_ff == 2'h0 && cmd_data == b;
	endsequence
	sequence s_len_end;
		ctake && cmd_last && cidx_ff == 2'h1 && cprev_ff == ACF_CMD_FILTER;
	endsequence
	sequence s_short(logic [7:0] b);
		rtake && rdr_last && rdr_short && rfirst_ff && rdr_data == b && filter_on;
	endsequence
	a_echo_reply: assert property (s_solo(ACF_CMD_ECHO)
		|-> ##2 rsp_valid && rsp_data == 8'h55 && rsp_last)
		else $error("echo reply wrong");
	a_echo_unlisten: assert property (s_solo(ACF_CMD_ECHO) |-> ##2 !listening)
		else $error("echo left listening on");
	a_rsp_holds: assert property (rsp_valid && !rsp_ready
		|=> rsp_valid && $stable(rsp_data))
		else $error("response byte changed before taken");
	a_busy_blocks: assert property (rsp_valid |-> !cmd_ready)
		else $error("command taken while answering");
	a_len0_report: assert property (s_len_end ##0 cmd_data == ACF_LEN_OFF
		|-> ##2 rsp_valid && rsp_data == ACF_RES_OK && !rsp_last && !filter_on)
		else $error("filter off answer wrong");
	a_badlen_error: assert property (s_len_end ##0 cmd_data > ACF_LEN_GET
		|-> ##2 rsp_valid && rsp_data == ACF_RES_BADLEN)
		else $error("bad length not refused");
	a_sens_ready: assert property (s_short(ACF_RQ_SENS) ##0 tag_state == ACF_ST_IDLE
		|-> ##2 ans_valid && tag_state == ACF_ST_READY_A)
		else $error("sense request not answered");
	a_wake_star: assert property (s_short(ACF_RQ_ALL) ##0 tag_state == ACF_ST_HALT
		|-> ##2 ans_valid && tag_state == ACF_ST_READY_A_S)
		else $error("wake request state wrong");
	a_off_buffers: assert property (rtake && rdr_last && !filter_on
		|-> ##[1:3] buf_valid)
		else $error("frame not buffered");
	a_stay_listen: assert property (listening && rtake && filter_on |=> listening[*4])
		else $error("listening dropped");
endmodule
bind acf_filter_cmd acf_checker i_chk (.*);

// ---- acf_host_model.sv ----
// Purpose: host controller model sending commands, taking answers
// Assumes: drives at the falling clock edge
// Notes: slow mode withholds rsp_ready every other cycle
`timescale 1ns/10ps
module acf_host_model
(
	// clock
	input  wire logic       clock,
	// command stream
	output logic            cmd_valid,
	output logic      [7:0] cmd_data,
	output logic            cmd_last,
	input  wire logic       cmd_ready,
	// response stream
	input  wire logic       rsp_valid,
	input  wire logic [7:0] rsp_data,
	output logic            rsp_ready,
	// control
	input  wire logic       slow,
	output logic            hung
);
	logic [7:0] rq[$];
	initial
	begin
		{cmd_valid, cmd_data, cmd_last, rsp_ready, hung} = 12'h002;
	end
	always @(negedge clock)
		rsp_ready <= slow ? ~rsp_ready : 1'b1;
	always @(posedge clock)
		if (rsp_valid && rsp_ready)
			rq.push_back(rsp_data);
	task automatic send(input logic [7:0] b[$]);
		int n;
		foreach (b[i])
		begin
			@(negedge clock);
			cmd_valid = 1'b1;
			cmd_data = b[i];
			cmd_last = (i == b.size() - 1);
			n = 0;
			while (!cmd_ready && n < 200)
			begin
				@(negedge clock);
				n++;
			end
			if (n == 200)
				hung = 1'b1;
		end
		@(negedge clock);
		cmd_valid = 1'b0;
		// released bus shows inverted data, never the old byte
		cmd_data = ~cmd_data;
		cmd_last = 1'b0;
	endtask
endmodule

// ---- acf_filter_cmd_bench.sv ----
// Purpose: self-checking bench for the filter command block
// Assumes: host model sends commands, bench sends reader frames
// Notes: seeded shift register makes every run repeat
`timescale 1ns/10ps
module acf_filter_cmd_bench
	import acf_pkg::*;
;
	logic       clock, rst_n, slow, hung, listen_start, listening, filter_on;
	logic       cmd_valid, cmd_last, cmd_ready, rsp_valid, rsp_last, rsp_ready;
	logic       rdr_valid, rdr_last, rdr_short, rdr_ready, ans_valid, ans_last, ans_ready;
	logic       buf_valid, buf_last, buf_ready;
	logic [7:0] cmd_data, rsp_data, rdr_data, ans_data, buf_data, tag_state;
	logic [7:0] aq[$], bq[$], none[$];
	logic [15:0] lf;
	int         n_fail, n_compared;
	acf_filter_cmd i_dut (.*);
	acf_host_model i_host (.*);
	initial
	begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	always @(posedge clock)
	begin
		if (ans_valid && ans_ready)
			aq.push_back(ans_data);
		if (buf_valid && buf_ready)
			bq.push_back(buf_data);
	end
	function automatic logic [7:0] rb();
		lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
		return lf[7:0];
	endfunction
	function automatic logic [7:0] bcc(input logic [7:0] u[4]);
		return u[0] ^ u[1] ^ u[2] ^ u[3];
	endfunction
	task automatic conclude();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e)
		begin
			$display("mismatch %s expected %h seen %h", nm, e, g);
			n_fail++;
		end
	endtask
	task automatic chkq(input string nm, input logic [7:0] e[$], input logic [7:0] g[$]);
		chk({nm, " count"}, 8'(e.size()), 8'(g.size()));
		foreach (e[i])
			if (i < g.size())
				chk(nm, e[i], g[i]);
	endtask
	task automatic wq(ref logic [7:0] q[$], input int k);
		int n;
		n = 0;
		while ((q.size() < k || (k < 0 && !rdr_ready)) && n < 200)
		begin
			@(negedge clock);
			n++;
		end
		if (n == 200)
		begin
			n_fail++;
			conclude();
		end
	endtask
	task automatic host(input logic [7:0] c[$], input logic [7:0] e[$]);
		i_host.send(c);
		wq(i_host.rq, e.size());
		chkq("response", e, i_host.rq);
		i_host.rq.delete();
	endtask
	task automatic rd(input logic [7:0] b[$], input logic s, input logic [7:0] e[$]);
		foreach (b[i])
		begin
			@(negedge clock);
			rdr_valid = 1'b1;
			rdr_data = b[i];
			rdr_last = (i == b.size() - 1);
			rdr_short = s;
			wq(none, -1);
		end
		@(negedge clock);
		rdr_valid = 1'b0;
		rdr_data = ~rdr_data;
		rdr_last = 1'b0;
		wq(aq, e.size());
		repeat (4) @(negedge clock);
		chkq("answer", e, aq);
		aq.delete();
	endtask
	initial
	begin
		repeat (20000) @(posedge clock);
		n_fail++;
		conclude();
	end
	initial
	begin
		logic [7:0] u[4];
		logic [7:0] q[$];
		logic [7:0] st[9];
		logic [7:0] a0, a1;
		n_fail = 0;
		n_compared = 0;
		lf = 16'h9082;
		{rst_n, slow, listen_start, rdr_valid, rdr_last, rdr_short} = 6'h00;
		{rdr_data, ans_ready, buf_ready} = 10'h003;
		repeat (12) @(posedge clock);
		@(negedge clock) rst_n = 1'b1;
		@(negedge clock) listen_start = 1'b1;
		@(negedge clock) listen_start = 1'b0;
		host('{8'h55}, '{8'h55});
		chk("listening", 8'h00, 8'(listening));
		$display("test echo done");
		st = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h80, 8'h81, 8'h82, 8'h83};
		slow = 1'b1;
		foreach (st[i])
		begin
			host('{8'h0D, 8'h01, st[i]}, '{8'h00, 8'h00});
			host('{8'h0D, 8'h02, 8'h00, 8'h00}, '{8'h00, 8'h01, st[i]});
		end
		slow = 1'b0;
		host('{8'h0D, 8'h03}, '{8'h82, 8'h00});
		host('{8'h0D, 8'h07, 8'h11, 8'h22}, '{8'h82, 8'h00});
		$display("test host commands done");
		buf_ready = 1'b0;
		repeat (9)
		begin
			q.push_back(rb());
			rd('{q[$]}, 1'b0, none);
		end
		chk("reader ready", 8'h00, 8'(rdr_ready));
		buf_ready = 1'b1;
		repeat (20) @(negedge clock);
		chkq("buffered", q, bq);
		bq.delete();
		$display("test buffer done");
		foreach (u[i])
			u[i] = rb();
		a0 = rb();
		a1 = rb();
		host('{8'h0D, 8'h07, a0, a1, 8'h20, u[0], u[1], u[2], u[3]}, '{8'h00, 8'h00});
		chk("filter", 8'h01, 8'(filter_on));
		host('{8'h0D, 8'h01, 8'h00}, '{8'h00, 8'h00});
		@(negedge clock) listen_start = 1'b1;
		@(negedge clock) listen_start = 1'b0;
		rd('{8'h26}, 1'b1, '{a0, a1});
		rd('{8'h93, 8'h20}, 1'b0, '{u[0], u[1], u[2], u[3], bcc(u)});
		rd('{8'h93, 8'h70, u[0], u[1], u[2], u[3], bcc(u)}, 1'b0, '{8'h20});
		chk("state", 8'h04, tag_state);
		rd('{8'h30, 8'h05}, 1'b0, none);
		chkq("buffered", '{8'h30, 8'h05}, bq);
		chk("listening", 8'h01, 8'(listening));
		host('{8'h0D, 8'h01, 8'h80}, '{8'h00, 8'h00});
		rd('{8'h52}, 1'b1, '{a0, a1});
		host('{8'h0D, 8'h02, 8'h00, 8'h00}, '{8'h00, 8'h01, 8'h81});
		chk("filter", 8'h01, 8'(filter_on));
		host('{8'h0D, 8'h00}, '{8'h00, 8'h01, 8'h81});
		chk("filter", 8'h00, 8'(filter_on));
		chk("host wait", 8'h00, 8'(hung));
		$display("test filter done");
		conclude();
	end
endmodule
